// File: hw/wiper_map.svh
// Offsets, field positions, reset values and timing counts of the wiper block
`ifndef WIPER_MAP_SVH
`define WIPER_MAP_SVH

// ==========================================================
// Clock and timing
`define MCLK_PERIOD_NS 4
`define NV_WRITE_TIME_NS 10000000
`define NV_WRITE_CYCLES (`NV_WRITE_TIME_NS / `MCLK_PERIOD_NS)

// ==========================================================
// Slave address: fixed high bits, pins in the low two bits
`define SLAVE_ADDR_HI 5'h0A
`define RW_BIT 0

// ==========================================================
// Memory locations
`define OFS_INITIAL_VALUE 8'h00
`define OFS_TABLE_ADDRESS 8'h08
`define OFS_WIPER 8'h09
`define OFS_TABLE_VALUE 8'h0A
`define OFS_TABLE_BASE 8'h80
`define PAGE_BITS 3

// ==========================================================
// Reset values and limits
`define WIPER_RESET 8'h00
`define WIPER_MAX 8'h7F
`define FIFO_WIDTH 16
`define FIFO_DEPTH 16

`endif

// File: hw/wiper_pkg.sv
// Types shared by the serial read and wiper source select design
`default_nettype none
package wiper_pkg;

  // ==========================================================
  // Serial slave states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_ADDR = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_WR_BYTE = 3'b011,
    ST_WR_ACK = 3'b100,
    ST_RD_BYTE = 3'b101,
    ST_RD_ACK = 3'b110
  } slave_state_t;

  typedef logic [7:0] byte_t;
  typedef logic [23:0] busy_count_t;

endpackage
`default_nettype wire

// File: hw/stream_if.sv
// Valid/ready word stream between the design's own modules
`timescale 1ns/1ns
`default_nettype none
interface stream_if #(
  parameter int WIDTH = 16
);
  logic valid;
  logic ready;
  logic [WIDTH-1:0] data;

  modport src (
    output valid,
    output data,
    input ready
  );
  modport snk (
    input valid,
    input data,
    output ready
  );
endinterface
`default_nettype wire

// File: hw/write_fifo.sv
// Write pair FIFO between the serial slave and the commit stage
`timescale 1ns/1ns
`default_nettype none
module write_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  stream_if.snk fill,
  stream_if.src drain
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr;
    logic [AW:0] rd;
  } fifo_state_t;

  fifo_state_t q, d;
  logic full, empty;

  // ==========================================================
  // Pointers carry one extra bit to tell full from empty
  always_comb begin
    d = q;
    empty = (q.wr == q.rd);
    full = (q.wr[AW-1:0] == q.rd[AW-1:0]) && (q.wr[AW] != q.rd[AW]);
    if (fill.valid && !full) begin
      d.mem[q.wr[AW-1:0]] = fill.data;
      d.wr = q.wr + 1'b1;
    end
    if (drain.ready && !empty) begin
      d.rd = q.rd + 1'b1;
    end
  end

  assign fill.ready = !full;
  assign drain.valid = !empty;
  assign drain.data = q.mem[q.rd[AW-1:0]];

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else if (ce_in) begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// File: hw/wiper_select.sv
// Wiper register with unsigned load or signed sum with the initial value
`timescale 1ns/1ns
`default_nettype none
`include "wiper_map.svh"
module wiper_select (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic load_in,
  input wire logic use_sum_in,
  input wire logic [7:0] value_in,
  input wire logic [7:0] initial_value_in,
  input wire logic [7:0] table_entry_in,
  output logic [7:0] wiper_out
);
  typedef struct packed {
    logic [7:0] wiper;
  } sel_state_t;

  sel_state_t q, d;

  // Clamp keeps a negative offset from wrapping to full scale
  function automatic logic [7:0] add_clamp(input logic [7:0] base, input logic [6:0] off);
    logic signed [9:0] sum;
    sum = $signed({2'b00, base}) + $signed({{3{off[6]}}, off});
    if (sum < 0) begin
      add_clamp = 8'h00;
    end else if (sum > $signed({2'b00, `WIPER_MAX})) begin
      add_clamp = `WIPER_MAX;
    end else begin
      add_clamp = sum[7:0];
    end
  endfunction

  always_comb begin
    d = q;
    if (load_in) begin
      // RL12: signed sum path
      if (use_sum_in) begin
        d.wiper = add_clamp(initial_value_in, table_entry_in[6:0]);
      // RL11: unsigned load path
      end else begin
        d.wiper = value_in;
      end
    end
  end

  assign wiper_out = q.wiper;

  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      q <= '{wiper: `WIPER_RESET};
    end else if (ce_in) begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// File: hw/serial_read_and_wiper_source_select.sv
// Serial slave read side, nonvolatile busy and wiper source selection
//
// Summary of operation
// RL1: During nonvolatile write time after STOP, own address is not acknowledged.
// RL2: Master polls the address or waits the full write time.
// RL3: Reads return data at the internal address counter.
// RL4: Single read: START, address with read bit, one byte, NACK, STOP.
// RL5: Master acknowledges each byte when it wants another one.
// RL6: Master answers the last byte with NACK and then STOP.
// RL7: Sequential reads advance the counter, wrapping from top to bottom.
// RL8: Bytes keep flowing while the master keeps acknowledging.
// RL9: Dummy write loads the counter, then repeated START and read.
// RL10: Update mode 0: initial value loads wiper at power-up, 00h writes set it.
// RL11: Conversion fetches table entry and loads it unsigned into wiper.
// RL12: With adder mode, conversion adds signed entry to initial value.
// RL13: Wiper access mode: host write to 09h loads wiper directly.
// RL14: Wiper access with adder: write to 09h loads entry plus initial value.
// RL15: Table address mode: write to 08h fetches entry, loads it unsigned.
// RL16: Table address with adder: write to 08h loads signed entry sum.
// RL17: Address mismatch ignores the bus until the next START.
// RL18: Multi-byte writes wrap within an eight-byte page.
`timescale 1ns/1ns
`default_nettype none
`include "wiper_map.svh"
module serial_read_and_wiper_source_select #(
  parameter int NV_WRITE_CYCLES = `NV_WRITE_CYCLES
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic ce_in,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  input wire logic [1:0] addr_pins_in,
  input wire logic update_mode_in,
  input wire logic adder_mode_in,
  input wire logic table_addr_mode_in,
  input wire logic wiper_access_in,
  input wire logic temp_valid_in,
  input wire logic [6:0] temp_index_in,
  output logic [7:0] wiper_out,
  output logic nv_busy_out
);
  // ==========================================================
  // State
  typedef struct packed {
    wiper_pkg::slave_state_t state;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [3:0] bit_cnt;
    wiper_pkg::byte_t shift;
    wiper_pkg::byte_t tx;
    wiper_pkg::byte_t addr_cnt;
    logic rw;
    logic first_byte;
    logic acked;
    logic wrote;
    logic busy;
    wiper_pkg::busy_count_t busy_cnt;
    logic sda_oe;
    logic init_loaded;
    logic [255:0][7:0] mem;
  } core_state_t;

  core_state_t q, d;

  stream_if #(.WIDTH(`FIFO_WIDTH)) wr_fill ();
  stream_if #(.WIDTH(`FIFO_WIDTH)) wr_drain ();

  logic scl_rise, scl_fall, start_seen, stop_seen;
  logic push_valid;
  logic [15:0] push_data;
  logic drain_ready;
  logic temp_event;
  logic wsel_load, wsel_sum;
  logic [7:0] wsel_value, wsel_entry;
  logic [7:0] wiper_now;
  logic [7:0] c_addr, c_data;

  // Table location for an index
  function automatic logic [7:0] table_loc(input logic [6:0] idx);
    logic [8:0] loc;
    loc = {1'b0, `OFS_TABLE_BASE} + {2'b00, idx};
    table_loc = loc[7:0];
  endfunction

  // Next sequential write location within its page
  function automatic logic [7:0] page_next(input logic [7:0] a);
    logic [`PAGE_BITS-1:0] low;
    low = a[`PAGE_BITS-1:0] + 1'b1;
    page_next = {a[7:`PAGE_BITS], low};
  endfunction

  // Read data; wiper is live, the rest comes from the array
  function automatic logic [7:0] read_loc(input logic [255:0][7:0] m, input logic [7:0] a,
                                          input logic [7:0] w);
    read_loc = (a == `OFS_WIPER) ? w : m[a];
  endfunction

  // ==========================================================
  // Next state
  always_comb begin
    d = q;
    push_valid = 1'b0;
    push_data = 16'h0000;
    drain_ready = 1'b0;
    wsel_load = 1'b0;
    wsel_sum = 1'b0;
    wsel_value = 8'h00;
    wsel_entry = q.mem[`OFS_TABLE_VALUE];
    c_addr = wr_drain.data[15:8];
    c_data = wr_drain.data[7:0];

    // Only the second and third stages feed edge detection
    d.scl_s = {q.scl_s[1:0], scl_in};
    d.sda_s = {q.sda_s[1:0], sda_in};
    d.pin_s1 = addr_pins_in;
    d.pin_s2 = q.pin_s1;
    scl_rise = q.scl_s[1] && !q.scl_s[2];
    scl_fall = !q.scl_s[1] && q.scl_s[2];
    start_seen = q.scl_s[1] && q.scl_s[2] && q.sda_s[2] && !q.sda_s[1];
    stop_seen = q.scl_s[1] && q.scl_s[2] && !q.sda_s[2] && q.sda_s[1];
    temp_event = temp_valid_in && update_mode_in && !table_addr_mode_in && !wiper_access_in;

    // NV write timer
    if (q.busy) begin
      if (q.busy_cnt == '0) begin
        d.busy = 1'b0;
      end else begin
        d.busy_cnt = q.busy_cnt - 1'b1;
      end
    end

    // ========================================================
    // Serial slave
    if (start_seen) begin
      // Repeated START drops the pending NV write
      d.state = wiper_pkg::ST_ADDR;
      d.bit_cnt = 4'h0;
      d.sda_oe = 1'b0;
      d.wrote = 1'b0;
    end else if (stop_seen) begin
      d.state = wiper_pkg::ST_IDLE;
      d.sda_oe = 1'b0;
      if (q.wrote) begin
        d.busy = 1'b1;
        d.busy_cnt = wiper_pkg::busy_count_t'(NV_WRITE_CYCLES - 1);
        d.wrote = 1'b0;
      end
    end else begin
      unique case (q.state)
        wiper_pkg::ST_IDLE: begin
          d.sda_oe = 1'b0;
        end
        wiper_pkg::ST_ADDR: begin
          if (scl_rise) begin
            d.shift = {q.shift[6:0], q.sda_s[1]};
            d.bit_cnt = q.bit_cnt + 1'b1;
          end else if (scl_fall && q.bit_cnt == 4'h8) begin
            // RL1: busy device stays silent
            // RL17: foreign address parks until START
            if (q.shift[7:1] == {`SLAVE_ADDR_HI, q.pin_s2} && !q.busy) begin
              d.sda_oe = 1'b1;
              d.rw = q.shift[`RW_BIT];
              d.state = wiper_pkg::ST_ADDR_ACK;
            end else begin
              d.state = wiper_pkg::ST_IDLE;
            end
          end
        end
        wiper_pkg::ST_ADDR_ACK: begin
          if (scl_fall) begin
            d.bit_cnt = 4'h0;
            if (q.rw) begin
              // RL3: data from the counter
              d.tx = read_loc(q.mem, q.addr_cnt, wiper_now);
              d.sda_oe = !d.tx[7];
              d.state = wiper_pkg::ST_RD_BYTE;
            end else begin
              d.sda_oe = 1'b0;
              d.first_byte = 1'b1;
              d.state = wiper_pkg::ST_WR_BYTE;
            end
          end
        end
        wiper_pkg::ST_WR_BYTE: begin
          if (scl_rise) begin
            d.shift = {q.shift[6:0], q.sda_s[1]};
            d.bit_cnt = q.bit_cnt + 1'b1;
          end else if (scl_fall && q.bit_cnt == 4'h8) begin
            d.state = wiper_pkg::ST_WR_ACK;
            if (q.first_byte) begin
              // RL9: counter loaded by dummy write
              d.addr_cnt = q.shift;
              d.first_byte = 1'b0;
              d.sda_oe = 1'b1;
            end else begin
              push_valid = 1'b1;
              push_data = {q.addr_cnt, q.shift};
              // Full FIFO answers NACK rather than losing the byte
              if (wr_fill.ready) begin
                // RL18: page wrap
                d.addr_cnt = page_next(q.addr_cnt);
                d.wrote = 1'b1;
                d.sda_oe = 1'b1;
              end
            end
          end
        end
        wiper_pkg::ST_WR_ACK: begin
          if (scl_fall) begin
            d.sda_oe = 1'b0;
            d.bit_cnt = 4'h0;
            d.state = wiper_pkg::ST_WR_BYTE;
          end
        end
        wiper_pkg::ST_RD_BYTE: begin
          if (scl_rise) begin
            d.bit_cnt = q.bit_cnt + 1'b1;
          end else if (scl_fall) begin
            if (q.bit_cnt == 4'h8) begin
              d.sda_oe = 1'b0;
              // RL7: full range wrap
              d.addr_cnt = q.addr_cnt + 1'b1;
              d.state = wiper_pkg::ST_RD_ACK;
            end else begin
              d.sda_oe = !q.tx[3'(7 - q.bit_cnt)];
            end
          end
        end
        wiper_pkg::ST_RD_ACK: begin
          if (scl_rise) begin
            d.acked = !q.sda_s[1];
          end else if (scl_fall) begin
            d.bit_cnt = 4'h0;
            // RL8: continue while acknowledged
            if (q.acked) begin
              d.tx = read_loc(q.mem, q.addr_cnt, wiper_now);
              d.sda_oe = !d.tx[7];
              d.state = wiper_pkg::ST_RD_BYTE;
            end else begin
              d.state = wiper_pkg::ST_IDLE;
            end
          end
        end
        default: begin
          d.state = wiper_pkg::ST_IDLE;
          d.sda_oe = 1'b0;
        end
      endcase
    end

    // ========================================================
    // Wiper source; power-up, then conversion, then host commits
    if (!q.init_loaded) begin
      // RL10: power-up copy
      d.init_loaded = 1'b1;
      wsel_load = 1'b1;
      wsel_value = q.mem[`OFS_INITIAL_VALUE];
    end else if (temp_event) begin
      // RL11: conversion indexes the table
      // RL12: adder mode sums with initial value
      d.mem[`OFS_TABLE_ADDRESS] = table_loc(temp_index_in);
      wsel_entry = q.mem[table_loc(temp_index_in)];
      d.mem[`OFS_TABLE_VALUE] = wsel_entry;
      wsel_load = 1'b1;
      wsel_sum = adder_mode_in;
      wsel_value = wsel_entry;
    end else begin
      // Conversion steals the cycle, so the FIFO backs up meanwhile
      drain_ready = 1'b1;
      if (wr_drain.valid) begin
        d.mem[c_addr] = c_data;
        if (!update_mode_in && c_addr == `OFS_WIPER) begin
          d.mem[c_addr] = q.mem[c_addr];
        end
        if (!update_mode_in && c_addr == `OFS_INITIAL_VALUE) begin
          // RL10: host write sets wiper
          wsel_load = 1'b1;
          wsel_value = c_data;
        end else if (update_mode_in && wiper_access_in && c_addr == `OFS_WIPER) begin
          // RL13: direct load
          // RL14: signed sum on write
          wsel_load = 1'b1;
          wsel_sum = adder_mode_in;
          wsel_value = c_data;
        end else if (update_mode_in && table_addr_mode_in && !wiper_access_in &&
                     c_addr == `OFS_TABLE_ADDRESS) begin
          // RL15: host picks table entry
          // RL16: signed entry summed
          wsel_entry = q.mem[table_loc(c_data[6:0])];
          d.mem[`OFS_TABLE_VALUE] = wsel_entry;
          wsel_load = 1'b1;
          wsel_sum = adder_mode_in;
          wsel_value = wsel_entry;
        end
      end
    end
  end

  assign wr_fill.valid = push_valid;
  assign wr_fill.data = push_data;
  assign wr_drain.ready = drain_ready;

  // ==========================================================
  // Submodules
  write_fifo #(
    .WIDTH(`FIFO_WIDTH),
    .DEPTH(`FIFO_DEPTH)
  ) u_fifo (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .fill(wr_fill),
    .drain(wr_drain)
  );

  wiper_select u_wsel (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .ce_in(ce_in),
    .load_in(wsel_load),
    .use_sum_in(wsel_sum),
    .value_in(wsel_value),
    .initial_value_in(q.mem[`OFS_INITIAL_VALUE]),
    .table_entry_in(wsel_entry),
    .wiper_out(wiper_now)
  );

  // ==========================================================
  // Outputs and registers
  assign sda_out = 1'b0;
  assign sda_oe_out = q.sda_oe;
  assign wiper_out = wiper_now;
  assign nv_busy_out = q.busy;

  // Array clears on reset; no nonvolatile retention is modelled
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else if (ce_in) begin
      q <= d;
    end
  end
endmodule
`default_nettype wire

// File: verification/wiper_top_properties.sv
// Port level checks of the serial read and wiper source select block
`timescale 1ns/1ns
`default_nettype none
module wiper_top_properties #(
  parameter int NV_WRITE_CYCLES = 400
) (
  input wire logic mclk_in,
  input wire logic rst_n_in,
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic update_mode_in,
  input wire logic adder_mode_in,
  input wire logic table_addr_mode_in,
  input wire logic wiper_access_in,
  input wire logic temp_valid_in,
  input wire logic [7:0] wiper_out,
  input wire logic nv_busy_out
);
  typedef struct packed {
    logic [23:0] busy_cnt;
  } watch_t;
  watch_t watch_q;
  watch_t watch_d;
  logic quiet;
  assign quiet = update_mode_in && !wiper_access_in && !table_addr_mode_in;
  always_comb begin
    watch_d = watch_q;
    watch_d.busy_cnt = nv_busy_out ? watch_q.busy_cnt + 24'h00_0001 : 24'h00_0000;
  end
  always_ff @(posedge mclk_in) begin
    if (!rst_n_in) begin
      watch_q <= '0;
    end else begin
      watch_q <= watch_d;
    end
  end
  // ==========
  // Checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  a_busy_no_ack: assert property (nv_busy_out |-> !sda_oe_out)
    else $error("sda driven while busy");
  a_busy_length: assert property ($fell(nv_busy_out) |-> watch_q.busy_cnt == NV_WRITE_CYCLES)
    else $error("busy length wrong");
  a_busy_at_stop: assert property ($rose(nv_busy_out) |-> $past(scl_in) && $past(sda_in))
    else $error("busy without stop");
  a_drive_scl_low: assert property ($rose(sda_oe_out) |-> !scl_in && !$past(scl_in))
    else $error("sda pulled while scl high");
  a_open_drain: assert property (sda_out == 1'b0)
    else $error("sda output not low");
  a_temp_loads: assert property ($changed(wiper_out) && $past(quiet) |-> $past(temp_valid_in))
    else $error("wiper moved without conversion");
  a_sum_clamped: assert property ($changed(wiper_out) && $past(update_mode_in)
    && $past(adder_mode_in) |-> wiper_out <= 8'h7F)
    else $error("sum out of range");
  a_temp_ignored: assert property (temp_valid_in && !quiet |=> $stable(wiper_out))
    else $error("conversion loaded wiper");
endmodule
bind serial_read_and_wiper_source_select wiper_top_properties #(
  .NV_WRITE_CYCLES(NV_WRITE_CYCLES)
) props (
  .mclk_in(mclk_in),
  .rst_n_in(rst_n_in),
  .scl_in(scl_in),
  .sda_in(sda_in),
  .sda_out(sda_out),
  .sda_oe_out(sda_oe_out),
  .update_mode_in(update_mode_in),
  .adder_mode_in(adder_mode_in),
  .table_addr_mode_in(table_addr_mode_in),
  .wiper_access_in(wiper_access_in),
  .temp_valid_in(temp_valid_in),
  .wiper_out(wiper_out),
  .nv_busy_out(nv_busy_out)
);
`default_nettype wire

// File: verification/bus_master_model.sv
// Serial bus master model, clock stands high between frames
`timescale 1ns/1ns
`default_nettype none
module bus_master_model (
  input wire logic mclk_in,
  input wire logic oe_in,
  output logic scl_out,
  output logic sda_out
);
  logic line;
  // Pull-up: released line reads high
  assign line = sda_out & ~oe_in;
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask
  // ==========
  // Bits, 20 clocks each
  task automatic wbit(input logic b);
    sda_out <= b;
    tick(5);
    scl_out <= 1'b1;
    tick(10);
    scl_out <= 1'b0;
    tick(5);
  endtask
  task automatic rbit(output logic b);
    sda_out <= 1'b1;
    tick(5);
    scl_out <= 1'b1;
    tick(5);
    b = line;
    tick(5);
    scl_out <= 1'b0;
    tick(5);
  endtask
  task automatic start;
    sda_out <= 1'b1;
    tick(8);
    scl_out <= 1'b1;
    tick(10);
    sda_out <= 1'b0;
    tick(10);
    scl_out <= 1'b0;
    tick(5);
  endtask
  task automatic stop;
    sda_out <= 1'b0;
    tick(8);
    scl_out <= 1'b1;
    tick(10);
    sda_out <= 1'b1;
    tick(10);
  endtask
  task automatic wbyte(input logic [7:0] d, output logic ack);
    for (int i = 7; i >= 0; i--) wbit(d[i]);
    rbit(ack);
  endtask
  // Ack for more, nack on last
  task automatic rbyte(output logic [7:0] d, input logic nack);
    logic b;
    for (int i = 0; i < 8; i++) begin
      rbit(b);
      d = {d[6:0], b};
    end
    wbit(nack);
  endtask
endmodule
`default_nettype wire

// File: verification/serial_read_and_wiper_source_select_tb_top.sv
// Self-checking bench of the serial read and wiper source select block
`timescale 1ns/1ns
`default_nettype none
`include "wiper_map.svh"
module serial_read_and_wiper_source_select_tb_top;
  localparam int NV = 400;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic ce = 1'b1;
  logic upd = 1'b0, add = 1'b0, tam = 1'b0, wac = 1'b0, tv = 1'b0;
  logic [6:0] tidx = 7'h00;
  logic [1:0] pins = 2'h1;
  logic scl, sda_m, sda_o, oe, busy;
  logic [7:0] wiper;
  logic [7:0] wq [$];
  int mismatches = 0, compares = 0, cycles = 0, seed = 33522, ptr = 0, wip = 0;
  int mem [256];
  always #2 mclk = ~mclk;
  bus_master_model m (.mclk_in(mclk), .oe_in(oe & ~sda_o), .scl_out(scl), .sda_out(sda_m));
  serial_read_and_wiper_source_select #(.NV_WRITE_CYCLES(NV)) uut (
    .mclk_in(mclk), .rst_n_in(rst_n), .ce_in(ce), .scl_in(scl), .sda_in(sda_m & (sda_o | ~oe)),
    .sda_out(sda_o), .sda_oe_out(oe), .addr_pins_in(pins), .update_mode_in(upd),
    .adder_mode_in(add), .table_addr_mode_in(tam), .wiper_access_in(wac),
    .temp_valid_in(tv), .temp_index_in(tidx), .wiper_out(wiper), .nv_busy_out(busy));
  // ==========
  // Model and checks
  function automatic int sum(input int e);
    int s;
    s = (e & 7'h3F) - (e & 7'h40) + mem[0];
    return s < 0 ? 0 : (s > 127 ? 127 : s);
  endfunction
  task automatic check(input logic [7:0] seen, input int exp);
    compares++;
    if (seen !== exp[7:0]) begin
      mismatches++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp[7:0]);
    end
  endtask
  task automatic report_and_stop;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 80000) begin
      mismatches++;
      report_and_stop;
    end
  end
  task automatic poll;
    logic a;
    for (int i = 0; i < 12; i++) begin
      m.start();
      m.wbyte({`SLAVE_ADDR_HI, pins, 1'b0}, a);
      m.stop();
      if (i == 0) check(a, 1);
      if (!a) break;
    end
    check(a, 0);
  endtask
  task automatic wr(input int loc);
    logic a;
    int p;
    p = loc;
    m.start();
    m.wbyte({`SLAVE_ADDR_HI, pins, 1'b0}, a);
    check(a, 0);
    m.wbyte(loc[7:0], a);
    foreach (wq[i]) begin
      m.wbyte(wq[i], a);
      check(a, 0);
      mem[p] = wq[i];
      if (!upd && p == 0) wip = wq[i];
      if (upd && wac && p == 9) wip = add ? sum(mem[10]) : wq[i];
      if (upd && tam && !wac && p == 8) begin
        mem[10] = mem[128 + wq[i][6:0]];
        wip = add ? sum(mem[10]) : mem[10];
      end
      p = (p & 248) | ((p + 1) & 7);
    end
    m.stop();
    ptr = p;
    wq.delete();
    poll();
  endtask
  task automatic rd(input int loc, input int n);
    logic a;
    logic [7:0] d;
    if (loc >= 0) begin
      m.start();
      m.wbyte({`SLAVE_ADDR_HI, pins, 1'b0}, a);
      m.wbyte(loc[7:0], a);
      ptr = loc;
    end
    m.start();
    m.wbyte({`SLAVE_ADDR_HI, pins, 1'b1}, a);
    check(a, 0);
    for (int i = 0; i < n; i++) begin
      m.rbyte(d, i == n - 1);
      check(d, ptr == 9 ? wip : mem[ptr]);
      ptr = (ptr + 1) & 255;
    end
    m.stop();
  endtask
  task automatic conv(input int idx);
    @(posedge mclk);
    tidx <= idx[6:0];
    tv <= 1'b1;
    @(posedge mclk);
    tv <= 1'b0;
    repeat (3) @(posedge mclk);
    if (upd && !wac && !tam) begin
      mem[8] = 128 + idx;
      mem[10] = mem[128 + idx];
      wip = add ? sum(mem[10]) : mem[10];
    end
    check(wiper, wip);
  endtask
  // ==========
  // Scenarios
  initial begin
    logic a;
    repeat (5) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (10) @(posedge mclk);
    check(wiper, 0);
    check({busy, oe}, 0);
    conv(3);
    $display("test reset done");
    wq.push_back(8'($random(seed)) & 8'h7F);
    wr(0);
    check(wiper, wip);
    // Update mode 0 ignores wiper location writes
    wq.push_back(8'h33);
    wr(9);
    check(wiper, wip);
    rd(9, 1);
    $display("test initial value done");
    for (int i = 0; i < 10; i++) wq.push_back(8'($random(seed)));
    wr(128);
    for (int i = 0; i < 8; i++) wq.push_back(8'($random(seed)));
    wr(248);
    rd(254, 4);
    rd(-1, 1);
    rd(128, 8);
    $display("test reads done");
    m.start();
    m.wbyte({`SLAVE_ADDR_HI, ~pins, 1'b0}, a);
    check(a, 1);
    m.wbyte(8'h80, a);
    m.wbyte(8'h55, a);
    m.stop();
    rd(-1, 2);
    $display("test foreign address done");
    upd <= 1'b1;
    // Frozen clock enable drops a conversion pulse
    ce <= 1'b0;
    tidx <= 7'h02;
    tv <= 1'b1;
    @(posedge mclk);
    tv <= 1'b0;
    repeat (2) @(posedge mclk);
    ce <= 1'b1;
    check(wiper, wip);
    for (int k = 0; k < 8; k++) begin
      add <= k[2];
      conv($random(seed) & 7);
    end
    $display("test conversions done");
    for (int k = 0; k < 4; k++) begin
      wac <= k < 2;
      tam <= k >= 2;
      add <= k[0];
      conv(5);
      wq.push_back(8'($random(seed)) & (k < 2 ? 8'h7F : 8'h07));
      wr(k < 2 ? 9 : 8);
      check(wiper, wip);
    end
    $display("test host modes done");
    report_and_stop();
  end
endmodule
`default_nettype wire
